// [hw/lop_pkg.sv]
// Constants and carrier types for the latched output port
package lop_pkg;

  // Port geometry
  localparam int LOP_LINES      = 32;
  localparam int LOP_SECT_LINES = 16;
  localparam int LOP_GRP_BITS   = 8;
  localparam int LOP_GROUPS     = 4;
  localparam int LOP_SECTIONS   = 2;

  // Register bus geometry
  localparam int LOP_AW      = 12;
  localparam int LOP_DW      = 32;
  localparam int LOP_REG_HI  = 11;
  localparam int LOP_REG_LO  = 10;
  localparam int LOP_IDX_HI  = 9;
  localparam int LOP_IDX_LO  = 2;

  // Address regions
  localparam logic [1:0] LOP_RGN_IO  = 2'h0;
  localparam logic [1:0] LOP_RGN_MEM = 2'h1;
  localparam logic [1:0] LOP_RGN_REG = 2'h2;

  // Control and status registers
  localparam logic [LOP_AW-1:0] LOP_STATUS = 12'h800;
  localparam logic [LOP_AW-1:0] LOP_OUTS   = 12'h804;
  localparam logic [LOP_AW-1:0] LOP_CTRL   = 12'h808;

  // Status field positions
  localparam int LOP_ST_EN_LSB = 0;
  localparam int LOP_ST_LINK   = 2;
  localparam int LOP_ST_W16    = 3;

  // Responses
  localparam logic [1:0] LOP_OKAY   = 2'h0;
  localparam logic [1:0] LOP_SLVERR = 2'h2;

  // Board switches
  typedef struct packed {
    logic [7:0] base;
    logic       reset_link;
    logic       width16;
  } lop_cfg_t;

  // Write request to one section
  typedef struct packed {
    logic [1:0]                we;
    logic [LOP_SECT_LINES-1:0] data;
    logic                      en_set;
  } lop_sect_wr_t;

endpackage

// [hw/lop_section.sv]
// One 16-line output section with its latches and enable
`timescale 1ns/1ns
module lop_section
  import lop_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Control
  input  wire logic                      clr,
  input  wire lop_pkg::lop_sect_wr_t     wr,
  // Outputs
  output logic [lop_pkg::LOP_SECT_LINES-1:0] lines,
  output logic                           en
);

  logic [LOP_SECT_LINES-1:0] latch;
  logic [LOP_SECT_LINES-1:0] next_latch;
  logic                      next_en;

  // Latch loading from byte-group writes
  always_comb
  begin
    next_latch = latch;
    for (int i = 0; i < LOP_SECT_LINES / LOP_GRP_BITS; i++)
    begin
      if (wr.we[i])
      begin
        next_latch[i*LOP_GRP_BITS +: LOP_GRP_BITS] = wr.data[i*LOP_GRP_BITS +: LOP_GRP_BITS];
      end
    end
    if (clr)
    begin
      next_latch = '0;
    end
  end

  // Section enable is set only by command
  always_comb
  begin
    next_en = (en | wr.en_set) & ~clr;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      latch <= '0;
    end
    else
    begin
      latch <= next_latch;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      en <= 1'b0;
    end
    else
    begin
      en <= next_en;
    end
  end

  // Outputs forced off until enabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lines <= '0;
    end
    else
    begin
      lines <= next_latch & {LOP_SECT_LINES{next_en}};
    end
  end

  sequence s_enable_cmd;
    wr.en_set && !clr;
  endsequence

  property p_off_until_en;
    @(posedge clk) disable iff (rst) !en |-> lines == '0;
  endproperty
  a_off_until_en: assert property (p_off_until_en) else $error("Lines active while disabled");

  property p_en_cmd;
    @(posedge clk) disable iff (rst) s_enable_cmd |=> en && lines == latch;
  endproperty
  a_en_cmd: assert property (p_en_cmd) else $error("Enable command not taken");

  property p_clear;
    @(posedge clk) disable iff (rst) clr |=> latch == '0 && !en && lines == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("Bus reset did not clear section");

  property p_load_low;
    @(posedge clk) disable iff (rst)
      wr.we[0] && !clr |=> latch[LOP_GRP_BITS-1:0] == $past(wr.data[LOP_GRP_BITS-1:0]);
  endproperty
  a_load_low: assert property (p_load_low) else $error("Low group not loaded");

  property p_hold;
    @(posedge clk) disable iff (rst) wr.we == 2'h0 && !clr |=> $stable(latch);
  endproperty
  a_hold: assert property (p_hold) else $error("Latch changed without write");

endmodule // lop_section

// [hw/lop_port.sv]
// Contract
// - One indicator per line, lit when active
// - Power-up reset forces all outputs off
// - Switch chooses whether bus reset clears
// - Outputs off until section enable command
// - Exactly four byte addresses decoded
// - Bus width 8 or 16, two indicators
// - Eight-bit switch places window in 256
// - Two sections of 16 latched lines
// - Bus interface decodes and carries data
`timescale 1ns/1ns
module lop_port
  import lop_pkg::*;
(
  // Clock and reset
  input  wire logic                        SYS_CLK,
  input  wire logic                        SYS_RST,
  // Board switches and host bus reset
  input  wire lop_pkg::lop_cfg_t           CFG_SWITCHES,
  input  wire logic                        HOST_BUS_RST,
  // AXI4-Lite write address and data
  input  wire logic [lop_pkg::LOP_AW-1:0]  S_AXI_AWADDR,
  input  wire logic [2:0]                  S_AXI_AWPROT,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [lop_pkg::LOP_DW-1:0]  S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [lop_pkg::LOP_AW-1:0]  S_AXI_ARADDR,
  input  wire logic [2:0]                  S_AXI_ARPROT,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic [lop_pkg::LOP_DW-1:0]       S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  // Output lines and indicators
  output logic [lop_pkg::LOP_LINES-1:0]    OUT_LINES,
  output logic [lop_pkg::LOP_LINES-1:0]    OUT_LEDS,
  output logic [lop_pkg::LOP_SECTIONS-1:0] SECTION_LEDS,
  output logic [1:0]                       WIDTH_LEDS
);

  logic                    wr_fire;
  logic                    rd_fire;
  logic [1:0]              wr_rgn;
  logic [7:0]              io_idx;
  logic [7:0]              rel;
  logic                    in_win;
  logic                    ctrl_hit;
  logic                    wr_bad;
  logic [LOP_GROUPS-1:0]   grp_we;
  logic [LOP_LINES-1:0]    grp_data;
  logic                    bus_clr;
  logic [LOP_SECTIONS-1:0] sect_en;
  logic [LOP_DW-1:0]       next_rdata;
  logic [1:0]              next_rresp;
  lop_sect_wr_t            sect_wr [LOP_SECTIONS];

  // Write and read handshakes
  assign wr_fire       = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_BVALID;
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY  = wr_fire;
  assign rd_fire       = S_AXI_ARVALID & ~S_AXI_RVALID;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // Window decode relative to the switch base
  assign wr_rgn   = S_AXI_AWADDR[LOP_REG_HI:LOP_REG_LO];
  assign io_idx   = S_AXI_AWADDR[LOP_IDX_HI:LOP_IDX_LO];
  assign rel      = io_idx - CFG_SWITCHES.base;
  assign in_win   = (wr_rgn == LOP_RGN_IO) && (rel < 8'(LOP_GROUPS));
  assign ctrl_hit = (S_AXI_AWADDR == LOP_CTRL);
  assign wr_bad   = (wr_rgn == LOP_RGN_REG) ? !(ctrl_hit || S_AXI_AWADDR == LOP_STATUS
                    || S_AXI_AWADDR == LOP_OUTS) : (wr_rgn != LOP_RGN_IO && wr_rgn != LOP_RGN_MEM);

  // Byte group steering for both bus widths
  always_comb
  begin
    grp_we   = '0;
    grp_data = '0;
    for (int g = 0; g < LOP_GROUPS; g++)
    begin
      if (CFG_SWITCHES.width16)
      begin
        grp_we[g] = wr_fire && in_win && (g[1] == rel[1]) && S_AXI_WSTRB[g[0]]
                    && (g[0] || !rel[0]);
        grp_data[g*LOP_GRP_BITS +: LOP_GRP_BITS] =
          S_AXI_WDATA[g[0]*LOP_GRP_BITS +: LOP_GRP_BITS];
      end
      else
      begin
        grp_we[g] = wr_fire && in_win && (g[1:0] == rel[1:0]) && S_AXI_WSTRB[0];
        grp_data[g*LOP_GRP_BITS +: LOP_GRP_BITS] = S_AXI_WDATA[LOP_GRP_BITS-1:0];
      end
    end
  end

  assign bus_clr = HOST_BUS_RST & CFG_SWITCHES.reset_link;

  // Two sections of sixteen lines
  for (genvar s = 0; s < LOP_SECTIONS; s++)
  begin : g_sect
    assign sect_wr[s].we     = grp_we[2*s +: 2];
    assign sect_wr[s].data   = grp_data[s*LOP_SECT_LINES +: LOP_SECT_LINES];
    assign sect_wr[s].en_set = wr_fire && ctrl_hit && S_AXI_WSTRB[0] && S_AXI_WDATA[s];
    lop_section u_sect
    (
      .clk   (SYS_CLK),
      .rst   (SYS_RST),
      .clr   (bus_clr),
      .wr    (sect_wr[s]),
      .lines (OUT_LINES[s*LOP_SECT_LINES +: LOP_SECT_LINES]),
      .en    (sect_en[s])
    );
  end

  // Indicators follow the lines, enables and width switch
  assign OUT_LEDS     = OUT_LINES;
  assign SECTION_LEDS = sect_en;

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      WIDTH_LEDS <= 2'h0;
    end
    else
    begin
      WIDTH_LEDS <= {CFG_SWITCHES.width16, ~CFG_SWITCHES.width16};
    end
  end

  // Write response
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= LOP_OKAY;
    end
    else if (wr_fire)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_bad ? LOP_SLVERR : LOP_OKAY;
    end
    else if (S_AXI_BREADY)
    begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Read data select
  always_comb
  begin
    next_rdata = '0;
    next_rresp = LOP_OKAY;
    case (S_AXI_ARADDR[LOP_REG_HI:LOP_REG_LO])
      LOP_RGN_IO, LOP_RGN_MEM: next_rdata = '0;
      LOP_RGN_REG:
      begin
        if (S_AXI_ARADDR == LOP_STATUS)
        begin
          next_rdata[LOP_ST_EN_LSB +: LOP_SECTIONS] = sect_en;
          next_rdata[LOP_ST_LINK] = CFG_SWITCHES.reset_link;
          next_rdata[LOP_ST_W16]  = CFG_SWITCHES.width16;
        end
        else if (S_AXI_ARADDR == LOP_OUTS)
        begin
          next_rdata = OUT_LINES;
        end
        else if (S_AXI_ARADDR != LOP_CTRL)
        begin
          next_rresp = LOP_SLVERR;
        end
      end
      default: next_rresp = LOP_SLVERR;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= LOP_OKAY;
    end
    else if (rd_fire)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= next_rdata;
      S_AXI_RRESP  <= next_rresp;
    end
    else if (S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  sequence s_wr_hs;
    wr_fire;
  endsequence

  sequence s_rd_hs;
    rd_fire;
  endsequence

  property p_bvalid;
    @(posedge SYS_CLK) disable iff (SYS_RST) s_wr_hs |=> S_AXI_BVALID;
  endproperty
  a_bvalid: assert property (p_bvalid) else $error("No write response");

  property p_rvalid;
    @(posedge SYS_CLK) disable iff (SYS_RST) s_rd_hs |=> S_AXI_RVALID;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("No read response");

  property p_outside;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      s_wr_hs ##0 (wr_rgn == LOP_RGN_IO && !in_win && !bus_clr) |=> $stable(OUT_LINES);
  endproperty
  a_outside: assert property (p_outside) else $error("Write outside window changed lines");

  property p_memory;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      s_wr_hs ##0 (wr_rgn == LOP_RGN_MEM && !bus_clr) |=> $stable(OUT_LINES);
  endproperty
  a_memory: assert property (p_memory) else $error("Memory cycle changed lines");

  property p_isolate;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      HOST_BUS_RST && !CFG_SWITCHES.reset_link && !wr_fire |=> $stable(OUT_LINES);
  endproperty
  a_isolate: assert property (p_isolate) else $error("Isolated bus reset changed lines");

  property p_width_led;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      1'b1 |=> WIDTH_LEDS == {$past(CFG_SWITCHES.width16), !$past(CFG_SWITCHES.width16)};
  endproperty
  a_width_led: assert property (p_width_led) else $error("Width indicators wrong");

  property p_word_write;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      s_wr_hs ##0 (in_win && CFG_SWITCHES.width16 && !rel[0] && S_AXI_WSTRB[1:0] == 2'h3)
      |-> grp_we[{rel[1], 1'b0}] && grp_we[{rel[1], 1'b1}];
  endproperty
  a_word_write: assert property (p_word_write) else $error("Word write missed a group");

endmodule // lop_port

// [sim/lop_host.sv]
// Host card model driving the port's register bus
`timescale 1ns/1ns
module lop_host
  import lop_pkg::*;
(
  // Clock
  input  wire logic                       clk,
  // Write side
  output logic [lop_pkg::LOP_AW-1:0]      awaddr,
  output logic                            awvalid,
  input  wire logic                       awready,
  output logic [lop_pkg::LOP_DW-1:0]      wdata,
  output logic [3:0]                      wstrb,
  output logic                            wvalid,
  input  wire logic                       wready,
  input  wire logic [1:0]                 bresp,
  input  wire logic                       bvalid,
  output logic                            bready,
  // Read side
  output logic [lop_pkg::LOP_AW-1:0]      araddr,
  output logic                            arvalid,
  input  wire logic                       arready,
  input  wire logic [lop_pkg::LOP_DW-1:0] rdata,
  input  wire logic [1:0]                 rresp,
  input  wire logic                       rvalid,
  output logic                            rready
);
  // Byte strobes for the next write, set by the bench
  logic [3:0] strobe;
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Address and data offered together; released payload shows inverted
  task automatic wr(input logic [LOP_AW-1:0] a, input logic [LOP_DW-1:0] d,
                    output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= strobe;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    awaddr  <= ~a;
    wdata   <= ~d;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  // Single read, data taken at the handshake edge
  task automatic rd(input logic [LOP_AW-1:0] a, output logic [LOP_DW-1:0] d,
                    output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
endmodule // lop_host

// [sim/test_latched_output_port_32.sv]
// Self-checking bench for the latched output port
`timescale 1ns/1ns
module test_latched_output_port_32;
  import lop_pkg::*;
  logic clk, sys_rst, hbr;
  lop_cfg_t cfg;
  logic [LOP_AW-1:0] awaddr, araddr;
  logic [LOP_DW-1:0] wdata, rdata, out_lines, out_leds, lat, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, sec_leds, width_leds, en;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int failures, checked, rel, p, i;
  lop_port uut (.SYS_CLK(clk), .SYS_RST(sys_rst), .CFG_SWITCHES(cfg), .HOST_BUS_RST(hbr),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .OUT_LINES(out_lines), .OUT_LEDS(out_leds),
    .SECTION_LEDS(sec_leds), .WIDTH_LEDS(width_leds));
  lop_host host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Latch model update for one I/O byte or word write
  function automatic logic [31:0] put(logic [31:0] l, int k, logic [15:0] v, logic w);
    if (!w)
      l[8*k +: 8] = v[7:0];
    else if (k % 2 == 0)
      l[8*k +: 16] = v;
    else
      l[8*k +: 8] = v[15:8];
    return l;
  endfunction
  function automatic logic [31:0] shown(logic [31:0] l, logic [1:0] e);
    return l & {{16{e[1]}}, {16{e[0]}}};
  endfunction
  task automatic look();
    chk(out_lines, shown(lat, en));
    chk(out_leds, shown(lat, en));
    chk(sec_leds, en);
  endtask
  // Window writes, some landing outside it
  task automatic burst(input int n);
    repeat (n)
    begin
      rel = int'($urandom % 7) - 1;
      d = $urandom;
      host.wr({2'h0, 8'(cfg.base + rel), 2'h0}, d, r);
      chk(r, LOP_OKAY);
      if (rel >= 0 && rel < 4)
        lat = put(lat, rel, d[15:0], cfg.width16);
      look();
    end
  endtask
  task automatic ctl(input logic [1:0] v);
    host.wr(LOP_CTRL, {30'h0, v}, r);
    chk(r, LOP_OKAY);
    en = en | v;
    look();
  endtask
  initial
  begin
    #100000;
    failures++;
    give_verdict();
  end
  initial
  begin
    sys_rst = 1'b1;
    hbr = 1'b0;
    cfg = '{base: 8'hFE, reset_link: 1'b1, width16: 1'b0};
    lat = '0;
    en = '0;
    host.strobe = 4'hF;
    void'($urandom(32'h4958));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    look();
    for (p = 0; p < 3; p++)
    begin
      cfg <= '{base: (p == 0) ? 8'hFE : 8'($urandom), reset_link: 1'b1, width16: p == 2};
      repeat (2) @(posedge clk);
      chk(width_leds, {cfg.width16, !cfg.width16});
      burst(12);
      host.wr({2'h1, cfg.base, 2'h0}, 32'h0000FFFF, r);
      chk(r, LOP_OKAY);
      look();
      host.rd(LOP_STATUS, d, r);
      chk(d, {28'h0, cfg.width16, cfg.reset_link, en});
      chk(r, LOP_OKAY);
      host.rd(LOP_OUTS, d, r);
      chk(d, shown(lat, en));
      ctl(p == 0 ? 2'h1 : 2'h2);
    end
    host.wr(12'hC00, 32'h1, r);
    chk(r, LOP_SLVERR);
    host.rd(12'h80C, d, r);
    chk(r, LOP_SLVERR);
    // Bus reset isolated, then linked
    for (i = 0; i < 2; i++)
    begin
      cfg.reset_link <= 1'(i);
      @(posedge clk);
      hbr <= 1'b1;
      @(posedge clk);
      hbr <= 1'b0;
      @(posedge clk);
      if (i == 1)
        {lat, en} = '0;
      look();
    end
    ctl(2'h3);
    burst(4);
    // Upper byte strobe alone on an even word address
    host.strobe = 4'h2;
    d = $urandom;
    host.wr({2'h0, cfg.base, 2'h0}, d, r);
    lat[15:8] = d[15:8];
    look();
    host.strobe = 4'hE;
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    {lat, en} = '0;
    @(posedge clk);
    look();
    // Enable word without its low byte strobe must not enable
    host.wr(LOP_CTRL, 32'h3, r);
    look();
    give_verdict();
  end
endmodule // test_latched_output_port_32
